// >>> design/pmt_cfg.svh
// Function
// - An 8-bit up-counter, period_counter, is readable and writable by the CPU.
// - The counter counts up from 00h and wraps to 00h on the increment after matching period_limit.
// - The counter is fed by the instruction clock through a prescaler of 1, 4 or 16 set by bits 1:0.
// - Each match clocks a 4-bit postscaler whose output is the timer interrupt event.
// - The postscaled event sets match_irq_flag in bit 1 of the flags register until software clears it.
// - Prescaler and postscaler clear on a counter write, a control write and every reset.
// - A control write leaves the counter value unchanged.
// - Any reset clears the counter to zero.
// - period_limit is an 8-bit read/write register that resets to all ones.
// - timer_run, bit 2 of control, gates counting so that a stopped timer uses little power.
// - Control sits at 12h: bit 7 reads zero, bits 6:3 postscale, bit 2 run, bits 1:0 prescale.
// - The counter and match timing are offered to the PWM unit as its time base.
// - match_irq_flag is set on the postscaled match event whatever the enables are.
// - The request reaches the CPU only when the local, peripheral and global enables are all set.
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// ------------------------------------------------------------
// Register byte addresses (printed offset times four)
// ------------------------------------------------------------
`define PMT_IDX_FLAGS      8'h0C
`define PMT_IDX_COUNT      8'h11
`define PMT_IDX_CTRL       8'h12
`define PMT_IDX_ENABLES    8'h8C
`define PMT_IDX_PERIOD     8'h92
`define PMT_IDX_GLOBAL     8'h0B
`define PMT_ADDR_FLAGS     10'h030
`define PMT_ADDR_COUNT     10'h044
`define PMT_ADDR_CTRL      10'h048
`define PMT_ADDR_ENABLES   10'h230
`define PMT_ADDR_PERIOD    10'h248
`define PMT_ADDR_GLOBAL    10'h02C

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define PMT_BIT_MATCH      1
`define PMT_BIT_RUN        2
`define PMT_BIT_GLOBAL_EN  7
`define PMT_BIT_PERIPH_EN  6
`define PMT_CTRL_MASK      8'h7F
`define PMT_CTRL_RESET     7'h00
`define PMT_COUNT_RESET    8'h00
`define PMT_PERIOD_RESET   8'hFF
`define PMT_INSTR_DIV      2'h3

`endif

// >>> design/pmt_pkg.sv
package pmt_pkg;

   // ---------------------------------------------------------
   // Control register layout
   // ---------------------------------------------------------
   typedef struct packed {
      logic [3:0] match_divide_select;
      logic       timer_run;
      logic [1:0] input_divide_select;
   } pmt_ctrl_t;

   // ---------------------------------------------------------
   // Time base offered to the PWM unit
   // ---------------------------------------------------------
   typedef struct packed {
      logic [7:0] period_counter;
      logic       match;
      logic       tick;
   } pmt_timebase_t;

endpackage : pmt_pkg

// >>> design/pmt_prescaler.sv
`timescale 1ns/1ps
`include "pmt_cfg.svh"

module pmt_prescaler
(
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   input  wire logic       clk_en_in,
   // Control
   input  wire logic       clear_in,
   input  wire logic       run_in,
   input  wire logic [1:0] select_in,
   // Output
   output logic            tick_out
);

   logic [1:0] quarter;
   logic [3:0] pre_count;
   logic       instr_tick;
   logic       pre_done;

   // ---------------------------------------------------------
   // Instruction clock: one tick every four clocks
   // ---------------------------------------------------------
   assign instr_tick = (quarter == `PMT_INSTR_DIV);

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         quarter <= 2'h0;
      else if (clk_en_in)
         quarter <= quarter + 2'h1;
   end

   // ---------------------------------------------------------
   // Prescaler
   // ---------------------------------------------------------
   always_comb
   begin
      if (select_in[1])
         pre_done = (pre_count == 4'hF);
      else if (select_in[0])
         pre_done = (pre_count[1:0] == 2'h3);
      else
         pre_done = 1'b1;
   end

   // Stopped timer holds pre_count; only the quarter counter keeps toggling
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         pre_count <= 4'h0;
      else if (clk_en_in)
      begin
         if (clear_in)
            pre_count <= 4'h0;
         else if (run_in && instr_tick)
            pre_count <= pre_done ? 4'h0 : pre_count + 4'h1;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         tick_out <= 1'b0;
      else if (clk_en_in)
         tick_out <= !clear_in && run_in && instr_tick && pre_done;
   end

endmodule : pmt_prescaler

// >>> design/pmt_timer.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "pmt_cfg.svh"

module pmt_timer
(
   // Clock and reset
   input  wire logic               mclk_in,
   input  wire logic               rst_n_in,
   input  wire logic               clk_en_in,
   // APB slave
   input  wire logic               psel_in,
   input  wire logic               penable_in,
   input  wire logic               pwrite_in,
   input  wire logic [11:0]        paddr_in,
   input  wire logic [31:0]        pwdata_in,
   input  wire logic [3:0]         pstrb_in,
   output logic      [31:0]        prdata_out,
   output logic                    pready_out,
   output logic                    pslverr_out,
   // Interrupt and time base
   output logic                    irq_out,
   output pmt_pkg::pmt_timebase_t  timebase_out
);

   pmt_pkg::pmt_ctrl_t ctrl;
   logic [7:0] period_counter;
   logic [7:0] period_limit;
   logic [3:0] post_count;
   logic       match_irq_flag;
   logic       match_irq_enable;
   logic       periph_irq_enable;
   logic       global_irq_enable;
   logic       pre_tick;
   logic       at_limit;
   logic       count_step;
   logic       post_event;
   logic       setup;
   logic       wr;
   logic       wr_count;
   logic       wr_ctrl;
   logic       wr_flags;
   logic       wr_enables;
   logic       wr_period;
   logic       wr_global;
   logic       mapped;
   logic       divider_clear;
   logic [7:0] next_read;

   // ---------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------
   // Writes land at the access edge where the master sees ready, never earlier
   assign setup      = psel_in && !penable_in;
   assign wr         = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
   assign wr_count   = wr && (paddr_in[11:2] == `PMT_ADDR_COUNT >> 2) ? 1'b1 : 1'b0;
   assign wr_ctrl    = wr && (paddr_in[11:2] == `PMT_ADDR_CTRL >> 2);
   assign wr_flags   = wr && (paddr_in[11:2] == `PMT_ADDR_FLAGS >> 2);
   assign wr_enables = wr && (paddr_in[11:2] == `PMT_ADDR_ENABLES >> 2);
   assign wr_period  = wr && (paddr_in[11:2] == `PMT_ADDR_PERIOD >> 2);
   assign wr_global  = wr && (paddr_in[11:2] == `PMT_ADDR_GLOBAL >> 2);

   assign divider_clear = wr_count || wr_ctrl;

   always_comb
   begin
      mapped    = 1'b1;
      next_read = 8'h00;
      unique case (paddr_in[11:2])
         `PMT_ADDR_FLAGS >> 2:
            next_read = {6'h00, match_irq_flag, 1'b0};
         `PMT_ADDR_COUNT >> 2:
            next_read = period_counter;
         `PMT_ADDR_CTRL >> 2:
            next_read = {1'b0, ctrl};
         `PMT_ADDR_ENABLES >> 2:
            next_read = {6'h00, match_irq_enable, 1'b0};
         `PMT_ADDR_PERIOD >> 2:
            next_read = period_limit;
         `PMT_ADDR_GLOBAL >> 2:
            next_read = {global_irq_enable, periph_irq_enable, 6'h00};
         default:
            mapped = 1'b0;
      endcase
   end

   // ---------------------------------------------------------
   // APB answer: ready in the access cycle, error if unmapped
   // ---------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end
      else if (clk_en_in)
      begin
         pready_out  <= setup;
         pslverr_out <= setup && !mapped;
         prdata_out  <= (setup && !pwrite_in) ? {24'h000000, next_read} : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------
   // Control and period registers
   // ---------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         ctrl <= `PMT_CTRL_RESET;
      else if (clk_en_in && wr_ctrl)
         ctrl <= pwdata_in[6:0];
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         period_limit <= `PMT_PERIOD_RESET;
      else if (clk_en_in && wr_period)
         period_limit <= pwdata_in[7:0];
   end

   // ---------------------------------------------------------
   // Prescaler
   // ---------------------------------------------------------
   pmt_prescaler u_prescaler
   (
      .mclk_in   (mclk_in),
      .rst_n_in  (rst_n_in),
      .clk_en_in (clk_en_in),
      .clear_in  (divider_clear),
      .run_in    (ctrl.timer_run),
      .select_in (ctrl.input_divide_select),
      .tick_out  (pre_tick)
   );

   // ---------------------------------------------------------
   // Counter
   // ---------------------------------------------------------
   assign at_limit   = (period_counter == period_limit);
   // A tick racing a control write is dropped, since the write restarts division
   assign count_step = pre_tick && ctrl.timer_run && !divider_clear;

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         period_counter <= `PMT_COUNT_RESET;
      else if (clk_en_in)
      begin
         if (wr_count)
            period_counter <= pwdata_in[7:0];
         else if (count_step)
            period_counter <= at_limit ? 8'h00 : period_counter + 8'h01;
      end
   end

   // ---------------------------------------------------------
   // Postscaler
   // ---------------------------------------------------------
   assign post_event = count_step && at_limit &&
                       (post_count == ctrl.match_divide_select);

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         post_count <= 4'h0;
      else if (clk_en_in)
      begin
         if (divider_clear)
            post_count <= 4'h0;
         else if (count_step && at_limit)
            post_count <= post_event ? 4'h0 : post_count + 4'h1;
      end
   end

   // ---------------------------------------------------------
   // Interrupt flag and enables
   // ---------------------------------------------------------
   // Set wins over a software clear in the same cycle
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         match_irq_flag <= 1'b0;
      else if (clk_en_in)
      begin
         if (post_event)
            match_irq_flag <= 1'b1;
         else if (wr_flags)
            match_irq_flag <= pwdata_in[`PMT_BIT_MATCH];
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         match_irq_enable <= 1'b0;
      else if (clk_en_in && wr_enables)
         match_irq_enable <= pwdata_in[`PMT_BIT_MATCH];
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         periph_irq_enable <= 1'b0;
         global_irq_enable <= 1'b0;
      end
      else if (clk_en_in && wr_global)
      begin
         periph_irq_enable <= pwdata_in[`PMT_BIT_PERIPH_EN];
         global_irq_enable <= pwdata_in[`PMT_BIT_GLOBAL_EN];
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         irq_out <= 1'b0;
      else if (clk_en_in)
         irq_out <= match_irq_flag && match_irq_enable &&
                    periph_irq_enable && global_irq_enable;
   end

   // ---------------------------------------------------------
   // PWM time base
   // ---------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         timebase_out <= '0;
      else if (clk_en_in)
      begin
         timebase_out.period_counter <= period_counter;
         timebase_out.match          <= count_step && at_limit;
         timebase_out.tick           <= count_step;
      end
   end

endmodule : pmt_timer

// >>> tb/pmt_timer_sva.sv
`timescale 1ns/1ps
`include "pmt_cfg.svh"

module pmt_timer_sva
(
   // Clock and reset
   input wire logic                   mclk_in,
   input wire logic                   rst_n_in,
   input wire logic                   clk_en_in,
   // APB
   input wire logic                   psel_in,
   input wire logic                   penable_in,
   input wire logic                   pwrite_in,
   input wire logic [11:0]            paddr_in,
   input wire logic [31:0]            pwdata_in,
   input wire logic [3:0]             pstrb_in,
   input wire logic [31:0]            prdata_out,
   input wire logic                   pready_out,
   input wire logic                   pslverr_out,
   // Interrupt and time base
   input wire logic                   irq_out,
   input wire pmt_pkg::pmt_timebase_t timebase_out
);
   // ---------------------------------------------------------
   // Shadows of writes, since register state is not visible
   // ---------------------------------------------------------
   logic       wr_go;
   logic [2:0] cnt_wr;
   logic       run_q;
   logic [2:0] en_q;
   logic [7:0] cnt;
   assign wr_go = psel_in & penable_in & pready_out & pwrite_in & clk_en_in & pstrb_in[0];
   assign cnt = timebase_out.period_counter;
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt_wr <= 3'h0;
         run_q <= 1'b0;
         en_q <= 3'h0;
      end
      else
      begin
         cnt_wr <= {cnt_wr[1:0], wr_go && paddr_in == 12'(`PMT_ADDR_COUNT)};
         if (wr_go && paddr_in == 12'(`PMT_ADDR_CTRL))
            run_q <= pwdata_in[2];
         if (wr_go && paddr_in == 12'(`PMT_ADDR_GLOBAL))
            en_q[2:1] <= pwdata_in[7:6];
         if (wr_go && paddr_in == 12'(`PMT_ADDR_ENABLES))
            en_q[0] <= pwdata_in[1];
      end
   end
   // ---------------------------------------------------------
   // Properties
   // ---------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_setup; psel_in && !penable_in && clk_en_in; endsequence
   sequence s_answer; pready_out && penable_in; endsequence
   a_ready_after_setup: assert property (s_setup |=> s_answer)
      else $error("no answer after setup");
   a_ready_pulse: assert property (clk_en_in && pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   a_err_read_zero: assert property (pslverr_out |-> prdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_idle_data_zero: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("read data outside answer");
   a_upper_zero: assert property (prdata_out[31:8] == 24'h0)
      else $error("upper read bits set");
   a_count_step: assert property ($changed(cnt) && !(|cnt_wr) |->
      cnt == $past(cnt) + 8'h01 || cnt == 8'h00) else $error("counter skipped");
   a_stop_holds: assert property (!run_q && !$past(run_q) && !$past(run_q, 2)
      && !(|cnt_wr) |-> $stable(cnt)) else $error("counter moved while stopped");
   a_irq_gated: assert property (irq_out |-> $past(&en_q))
      else $error("interrupt without all enables");
endmodule : pmt_timer_sva

bind pmt_timer pmt_timer_sva u_sva (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .irq_out(irq_out), .timebase_out(timebase_out));

// >>> tb/tb.sv
`timescale 1ns/1ps
`include "pmt_cfg.svh"

module tb;
   logic                   mclk_in = 1'b0;
   logic                   rst_n_in = 1'b0;
   logic                   clk_en = 1'b1;
   logic                   psel = 1'b0;
   logic                   pen = 1'b0;
   logic                   pwr = 1'b0;
   logic [11:0]            paddr = 12'h000;
   logic [31:0]            pwdata = 32'h0;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic                   irq;
   pmt_pkg::pmt_timebase_t tbase;
   int                     err_count = 0;
   int                     cmp_count = 0;
   localparam logic [11:0] AF = 12'(`PMT_ADDR_FLAGS);
   localparam logic [11:0] AC = 12'(`PMT_ADDR_COUNT);
   localparam logic [11:0] AT = 12'(`PMT_ADDR_CTRL);
   localparam logic [11:0] AE = 12'(`PMT_ADDR_ENABLES);
   localparam logic [11:0] AP = 12'(`PMT_ADDR_PERIOD);
   localparam logic [11:0] AG = 12'(`PMT_ADDR_GLOBAL);

   pmt_timer uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .irq_out(irq), .timebase_out(tbase));

   initial
   begin
      forever #2.5 mclk_in = ~mclk_in;
   end

   // ---------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check

   task automatic stuck;
      err_count++;
      report_and_stop();
   endtask : stuck

   // One transfer, then an idle cycle so two calls never collide
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_in);
      pen <= 1'b1;
      do
      begin
         @(posedge mclk_in);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         stuck();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge mclk_in);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, a, d, rd, er);
   endtask : wr

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, a, 32'h0, rd, er);
      check(rd, exp);
   endtask : rchk

   // Cycles until the counter moves; the new value must follow the old
   task automatic wait_step(output int n);
      logic [7:0] v;
      v = tbase.period_counter;
      n = 0;
      do
      begin
         @(posedge mclk_in);
         n++;
      end
      while (tbase.period_counter === v && n < 200);
      if (n >= 200)
         stuck();
      check(32'(tbase.period_counter), (v == 8'h03) ? 32'h0 : 32'(v) + 32'h1);
   endtask : wait_step

   // Match pulse must come with the tick and with the limit on show
   task automatic wait_match(input logic [7:0] lim);
      int n;
      n = 0;
      do
      begin
         @(posedge mclk_in);
         n++;
      end
      while (tbase.match !== 1'b1 && n < 100);
      if (n >= 100)
         stuck();
      check({31'h0, tbase.tick}, 32'h1);
      check(32'(tbase.period_counter), 32'(lim));
   endtask : wait_match

   // ---------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------
   task automatic t_regs;
      logic [31:0] d;
      logic        e;
      rchk(AC, 32'h0);
      rchk(AP, 32'hFF);
      rchk(AT, 32'h0);
      wr(AP, 32'h5A);
      rchk(AP, 32'h5A);
      wr(AT, 32'hFB);
      rchk(AT, 32'h7B);
      wr(AC, 32'h33);
      wr(AT, 32'h00);
      rchk(AC, 32'h33);
      apb(1'b0, 12'hFFC, 32'h0, d, e);
      check(d, 32'h0);
      check({31'h0, e}, 32'h1);
      $display("t_regs done");
   endtask : t_regs

   task automatic t_count;
      int n;
      wr(AP, 32'h3);
      wr(AC, 32'h0);
      for (int s = 0; s < 4; s++)
      begin
         wr(AT, 32'h4 | 32'(s));
         wait_step(n);
         wait_step(n);
         check(32'(n), (s == 0) ? 32'h4 : (s == 1) ? 32'h10 : 32'h40);
      end
      $display("t_count done");
   endtask : t_count

   // Clock enable low must freeze the running counter, which then resumes
   task automatic t_hold;
      logic [7:0] v;
      int         n;
      wr(AT, 32'h4);
      wait_step(n);
      clk_en <= 1'b0;
      @(posedge mclk_in);
      v = tbase.period_counter;
      repeat (20) @(posedge mclk_in);
      check(32'(tbase.period_counter), 32'(v));
      clk_en <= 1'b1;
      wait_step(n);
      $display("t_hold done");
   endtask : t_hold

   task automatic t_post;
      logic [7:0] g [3];
      g = '{8'h40, 8'h80, 8'hC0};
      wr(AT, 32'h0);
      wr(AF, 32'h0);
      wr(AE, 32'h2);
      wr(AP, 32'h1);
      wr(AC, 32'h0);
      wr(AT, 32'h14);
      wait_match(8'h01);
      wait_match(8'h01);
      rchk(AF, 32'h0);
      wait_match(8'h01);
      rchk(AF, 32'h2);
      wr(AT, 32'h0);
      @(posedge mclk_in);
      check({31'h0, irq}, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         wr(AG, 32'(g[i]));
         @(posedge mclk_in);
         check({31'h0, irq}, (i == 2) ? 32'h1 : 32'h0);
      end
      wr(AF, 32'h0);
      @(posedge mclk_in);
      check({31'h0, irq}, 32'h0);
      rchk(AF, 32'h0);
      $display("t_post done");
   endtask : t_post

   initial
   begin
      repeat (8) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      t_regs();
      t_count();
      t_hold();
      t_post();
      report_and_stop();
   end
endmodule : tb
